// ---- rtl/tcs_defs.svh ----
// Register offsets, field positions and reset values of the timer
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH
// Byte offsets of the register words
`define TCS_OFF_CTRL    5'h00
`define TCS_OFF_STAT    5'h04
`define TCS_OFF_RELOAD  5'h08
`define TCS_OFF_MATCH   5'h0C
`define TCS_OFF_SNAP    5'h10
// Control word fields
`define TCS_CTRL_W      13
`define TCS_C_MODE_LO   0
`define TCS_C_MODE_HI   2
`define TCS_C_RUN       3
`define TCS_C_CPE       4
`define TCS_C_GTE       5
`define TCS_C_OC_LO     6
`define TCS_C_OC_HI     7
`define TCS_C_IM_LO     8
`define TCS_C_IM_HI     10
`define TCS_C_EXT       11
`define TCS_C_BYP       12
// Status word fields
`define TCS_STAT_W      7
`define TCS_S_MATCH     0
`define TCS_S_TMO       1
`define TCS_S_GATE      2
`define TCS_S_CMP       3
`define TCS_S_ON        4
`define TCS_S_GLVL      5
`define TCS_S_OUT       6
// Reset values
`define TCS_CTRL_RST    13'h0000
`define TCS_DATA_RST    32'h0000_0000
`endif

// ---- rtl/tcs_pkg.sv ----
// Types shared by the timer design
`default_nettype none
package tcs_pkg;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN  = 3'h2,
    ST_HOLD = 3'h4
  } tcs_state_t;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_CAP = 3'h0,
    MODE_SQ  = 3'h1
  } tcs_mode_t;
  // Output pin actions
  typedef enum logic [1:0] {
    OC_NONE = 2'h0,
    OC_TOG  = 2'h1,
    OC_LOW  = 2'h2,
    OC_HIGH = 2'h3
  } tcs_oc_t;
endpackage : tcs_pkg
`default_nettype wire

// ---- rtl/tcs_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module tcs_sync #(
  parameter int         W   = 1,    // Number of pins
  parameter logic [W-1:0] RST = '0  // Level held during reset
) (
  input  wire logic         clk_i,    // System clock
  input  wire logic         rst_n_i,  // Synchronous reset, low
  input  wire logic         ce_i,     // Clock enable
  input  wire logic [W-1:0] pin_i,    // Asynchronous pins
  output logic      [W-1:0] lvl_o     // Filtered levels
);
  generate
    if (W < 1) begin : g_chk
      $error("tcs_sync needs at least one pin");
    end
  endgenerate

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_q;  // First stage, read by second only
      logic s2_q;  // Second stage
      logic s3_q;  // Third stage
      // Shift chain; level moves once stages two and three agree
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          s1_q     <= RST[g];
          s2_q     <= RST[g];
          s3_q     <= RST[g];
          lvl_o[g] <= RST[g];
        end else if (ce_i) begin
          s1_q <= pin_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_o[g] <= s3_q;
          end
        end
      end
    end
  endgenerate
endmodule : tcs_sync
`default_nettype wire

// ---- rtl/tcs_timer.sv ----
// Capture/compare and square-wave timer with Avalon-MM registers
`include "tcs_defs.svh"
`default_nettype none
// Functional notes
// - Mode 000 selects capture/compare operation
// - Both enables start timer, load on tick
// - Gate never stops counter in capture mode
// - Snapshot follows counter one cycle later
// - Gate rise sets flag, freezes snapshot, W1C
// - Gate disabled means no capture at all
// - Status shows synchronised gate level always
// - Match sets flags and drives output pin
// - Zero sets timeout, clears compare, reloads
// - Masked flags drive the interrupt line
// - Match write may race compare, old used
// - Mode 001 selects square-wave operation
// - Square start may wait on gate assertion
// - Timeout every reload plus one ticks, toggle
// - Gate negation pauses, sets flag, resumes
// - Gate disabled: start on tick, no flag
// - Reload write may race load, old used
// - 8-bit prescaler feeds 16-bit down-counter
// - Clock is pin or half system clock
module tcs_timer #(
  parameter int CNT_W = 16,  // Counter width
  parameter int PRE_W = 8    // Prescaler width
) (
  input  wire logic        CLK_I,            // System clock
  input  wire logic        RESET_N_I,        // Synchronous reset, low
  input  wire logic        CE_I,             // Clock enable
  input  wire logic [4:0]  AVS_ADDRESS_I,    // Byte address
  input  wire logic [3:0]  AVS_BYTEENABLE_I, // Byte lanes
  input  wire logic        AVS_READ_I,       // Read request
  input  wire logic        AVS_WRITE_I,      // Write request
  input  wire logic [31:0] AVS_WRITEDATA_I,  // Write data
  output logic      [31:0] AVS_READDATA_O,   // Read data
  output logic             AVS_WAITREQUEST_O,// Stall
  input  wire logic        GATE_PIN_N_I,     // Gate pin, active low
  input  wire logic        EXT_CLOCK_PIN_I,  // External count clock
  output logic             WAVE_O,           // Waveform pin
  output logic             IRQ_O             // Interrupt line
);
  // Parameter check
  generate
    if (CNT_W < 2 || CNT_W > 32 || PRE_W < 1 || PRE_W > 16) begin : g_chk
      $error("tcs_timer: unsupported counter or prescaler width");
    end
  endgenerate

  // Registers
  logic [`TCS_CTRL_W-1:0] ctrl_q;   // Control word
  logic [CNT_W-1:0]       reload_q; // Reload value
  logic [CNT_W-1:0]       match_q;  // Match value
  logic [CNT_W-1:0]       snap_q;   // Count snapshot
  logic [CNT_W-1:0]       cnt_q;    // Down-counter
  logic [PRE_W-1:0]       pre_q;    // Prescaler
  logic                   load_q;   // Load due on next tick
  logic                   tc_q;     // Match flag
  logic                   to_q;     // Timeout flag
  logic                   tg_q;     // Gate event flag
  logic                   cmp_q;    // Compare status bit
  logic                   wave_q;   // Output pin level
  logic                   half_q;   // Half system clock
  logic                   sel_q;    // Previous selected clock
  logic                   gprev_q;  // Previous gate level
  logic                   ack_q;    // Bus answer phase
  logic [31:0]            rdata_q;  // Read data
  tcs_pkg::tcs_state_t    st_q;     // Sequencer state
  tcs_pkg::tcs_state_t    st_d;     // Next state

  // Control fields
  wire [2:0] mode    = ctrl_q[`TCS_C_MODE_HI:`TCS_C_MODE_LO];
  wire       soft_run_bit     = ctrl_q[`TCS_C_RUN];
  wire       clock_path_enable     = ctrl_q[`TCS_C_CPE];
  wire       gate_enable_bit     = ctrl_q[`TCS_C_GTE];
  wire [1:0] oc      = ctrl_q[`TCS_C_OC_HI:`TCS_C_OC_LO];
  wire [2:0] imask   = ctrl_q[`TCS_C_IM_HI:`TCS_C_IM_LO];
  wire       use_ext = ctrl_q[`TCS_C_EXT];
  wire       bypass  = ctrl_q[`TCS_C_BYP];
  wire       is_cap  = (mode == tcs_pkg::MODE_CAP);
  wire       is_sq   = (mode == tcs_pkg::MODE_SQ);

  // Synchronised pins: bit 0 gate, bit 1 external clock
  logic [1:0] pin_lvl;  // Filtered levels
  tcs_sync #(
    .W   (2),
    .RST (2'h1)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RESET_N_I),
    .ce_i    (CE_I),
    .pin_i   ({EXT_CLOCK_PIN_I, GATE_PIN_N_I}),
    .lvl_o   (pin_lvl)
  );
  wire gate_lvl  = pin_lvl[0];
  wire gate_on   = ~gate_lvl;               // Gate asserted
  wire gate_rise = gate_lvl & ~gprev_q;     // Pin rises: negation

  // Clock selection and falling-edge detect
  wire sel_lvl  = use_ext ? pin_lvl[1] : half_q;
  wire sel_fall = sel_q & ~sel_lvl;
  wire pre_tick = sel_fall & (pre_q == '0);
  wire cnt_clk  = bypass ? sel_fall : pre_tick;

  // Enables
  wire go      = soft_run_bit & clock_path_enable;
  wire gate_ok = ~(is_sq & gate_enable_bit) | gate_on;
  wire running = (st_q == tcs_pkg::ST_RUN);
  wire tick    = running & cnt_clk;

  // Counter next value and events
  wire [CNT_W-1:0] cnt_nxt = load_q ? reload_q : cnt_q - 1'b1;
  wire to_ev    = tick & (cnt_nxt == '0);
  wire match_ev = tick & (cnt_nxt == match_q);
  wire gate_ev  = gate_enable_bit & (is_cap | is_sq) & gate_rise & soft_run_bit;

  // Bus decode
  wire sel_ctrl = (AVS_ADDRESS_I == `TCS_OFF_CTRL);
  wire sel_stat = (AVS_ADDRESS_I == `TCS_OFF_STAT);
  wire sel_rel  = (AVS_ADDRESS_I == `TCS_OFF_RELOAD);
  wire sel_mat  = (AVS_ADDRESS_I == `TCS_OFF_MATCH);
  wire sel_snap = (AVS_ADDRESS_I == `TCS_OFF_SNAP);
  wire wr_en    = AVS_WRITE_I & ack_q;
  wire rd_take  = AVS_READ_I & ~ack_q;
  wire [31:0] bmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                       {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  wire [31:0] wbits = AVS_WRITEDATA_I & bmask;
  wire [31:0] ctrl32 = {{(32-`TCS_CTRL_W){1'b0}}, ctrl_q};
  wire [31:0] ctrl_w = (ctrl32 & ~bmask) | wbits;
  wire [31:0] rel32  = {{(32-CNT_W){1'b0}}, reload_q};
  wire [31:0] rel_w  = (rel32 & ~bmask) | wbits;
  wire [31:0] mat32  = {{(32-CNT_W){1'b0}}, match_q};
  wire [31:0] mat_w  = (mat32 & ~bmask) | wbits;
  wire clr_stat = wr_en & sel_stat;
  wire clr_tc   = clr_stat & wbits[`TCS_S_MATCH];
  wire clr_to   = clr_stat & wbits[`TCS_S_TMO];
  wire clr_tg   = clr_stat & wbits[`TCS_S_GATE];

  // Status word
  wire [`TCS_STAT_W-1:0] stat = {wave_q, gate_lvl, running, cmp_q,
                                 tg_q, to_q, tc_q};
  wire [31:0] rmux = sel_ctrl ? ctrl32 :
                     sel_stat ? {{(32-`TCS_STAT_W){1'b0}}, stat} :
                     sel_rel  ? rel32 :
                     sel_mat  ? mat32 :
                     sel_snap ? {{(32-CNT_W){1'b0}}, snap_q} :
                                `TCS_DATA_RST;

  // Output pin next level
  wire match_drv = is_cap & match_ev;
  logic wave_d;  // Next pin level
  always_comb begin
    wave_d = wave_q;
    if (match_drv) begin
      case (oc)
        tcs_pkg::OC_TOG:  wave_d = ~wave_d;
        tcs_pkg::OC_LOW:  wave_d = 1'b0;
        tcs_pkg::OC_HIGH: wave_d = 1'b1;
        default:          wave_d = wave_d;
      endcase
    end
    if (to_ev) begin
      case (oc)
        tcs_pkg::OC_TOG:  wave_d = ~wave_d;
        tcs_pkg::OC_LOW:  wave_d = is_cap;
        tcs_pkg::OC_HIGH: wave_d = ~is_cap;
        default:          wave_d = wave_d;
      endcase
    end
  end

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      tcs_pkg::ST_IDLE: begin
        if (go && gate_ok) st_d = tcs_pkg::ST_RUN;
      end
      tcs_pkg::ST_RUN: begin
        if (!go) st_d = tcs_pkg::ST_IDLE;
        else if (!gate_ok) st_d = tcs_pkg::ST_HOLD;
      end
      tcs_pkg::ST_HOLD: begin
        if (!go) st_d = tcs_pkg::ST_IDLE;
        else if (gate_ok) st_d = tcs_pkg::ST_RUN;
      end
      default: st_d = tcs_pkg::ST_IDLE;
    endcase
  end

  // Bus slave: one wait cycle per access
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ack_q   <= 1'b0;
      rdata_q <= `TCS_DATA_RST;
      ctrl_q  <= `TCS_CTRL_RST;
      reload_q <= '0;
      match_q <= '0;
    end else if (CE_I) begin
      ack_q <= (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
      if (rd_take) rdata_q <= rmux;
      if (wr_en && sel_ctrl) ctrl_q <= ctrl_w[`TCS_CTRL_W-1:0];
      if (wr_en && sel_rel) reload_q <= rel_w[CNT_W-1:0];
      if (wr_en && sel_mat) match_q <= mat_w[CNT_W-1:0];
    end
  end

  // Clock generation and edge history
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      half_q  <= 1'b0;
      sel_q   <= 1'b0;
      gprev_q <= 1'b1;
    end else if (CE_I) begin
      half_q  <= ~half_q;
      sel_q   <= sel_lvl;
      gprev_q <= gate_lvl;
    end
  end

  // Prescaler, counter and sequencer; run bit clear holds reset
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I || (CE_I && !soft_run_bit)) begin
      st_q   <= tcs_pkg::ST_IDLE;
      pre_q  <= '1;
      cnt_q  <= '0;
      load_q <= 1'b0;
    end else if (CE_I) begin
      st_q <= st_d;
      if (st_q == tcs_pkg::ST_IDLE && st_d == tcs_pkg::ST_RUN) begin
        load_q <= 1'b1;
        pre_q  <= '1;
      end else if (running && sel_fall) begin
        pre_q <= pre_q - 1'b1;
      end
      if (tick) begin
        cnt_q  <= cnt_nxt;
        load_q <= (cnt_nxt == '0);
      end
    end
  end

  // Flags, snapshot and pin; a flag set wins over a write-one clear
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I || (CE_I && !soft_run_bit)) begin
      tc_q   <= 1'b0;
      to_q   <= 1'b0;
      tg_q   <= 1'b0;
      cmp_q  <= 1'b0;
      wave_q <= 1'b0;
      snap_q <= '0;
    end else if (CE_I) begin
      tc_q   <= match_ev | (tc_q & ~clr_tc);
      to_q   <= to_ev | (to_q & ~clr_to);
      tg_q   <= gate_ev | (tg_q & ~clr_tg);
      cmp_q  <= ~to_ev & (match_ev | cmp_q);
      wave_q <= wave_d;
      if (!tg_q) snap_q <= cnt_q;
    end
  end

  // Outputs
  // Stall also while frozen, so no answer is given that commits nothing
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~(ack_q & CE_I);
  assign AVS_READDATA_O    = rdata_q;
  assign WAVE_O            = wave_q;
  assign IRQ_O = |({tg_q, to_q, tc_q} & imask);

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I || !CE_I);

  sequence s_start;
    st_q == tcs_pkg::ST_IDLE && go && gate_ok && CE_I;
  endsequence
  sequence s_loaded;
    running && load_q;
  endsequence
  sequence s_gate_stop;
    is_sq && gate_enable_bit && running && go && gate_rise;
  endsequence

  AST_START: assert property (s_start |=> s_loaded)
    else $error("timer did not start with a pending load");
  AST_RELOAD: assert property (tick && load_q
    |=> cnt_q == $past(reload_q))
    else $error("counter not loaded from reload value");
  AST_NO_STOP: assert property (is_cap && running && go
    |=> st_q != tcs_pkg::ST_HOLD)
    else $error("gate paused counter in capture mode");
  AST_SHADOW: assert property (!tg_q && soft_run_bit
    |=> snap_q == $past(cnt_q))
    else $error("snapshot does not follow counter");
  AST_FREEZE: assert property (tg_q && soft_run_bit ##1 tg_q && soft_run_bit
    |-> $stable(snap_q))
    else $error("snapshot moved while frozen");
  AST_NO_GATE: assert property (!gate_enable_bit && !tg_q && soft_run_bit
    |=> !tg_q)
    else $error("gate flag set with gate disabled");
  // A match on the timeout tick leaves the compare bit clear
  AST_MATCH: assert property (match_ev && soft_run_bit
    |=> tc_q && cmp_q == !$past(to_ev))
    else $error("match flags not set");
  AST_TIMEOUT: assert property (to_ev && soft_run_bit
    |=> to_q && !cmp_q && load_q)
    else $error("timeout did not flag and arm reload");
  // Match and timeout on one tick toggle twice in capture mode
  AST_TOGGLE: assert property (to_ev && soft_run_bit && oc == tcs_pkg::OC_TOG
    |=> wave_q == ($past(wave_q) ^ !$past(match_drv)))
    else $error("pin did not invert at timeout");
  AST_GATE_HOLD: assert property (s_gate_stop
    |=> st_q == tcs_pkg::ST_HOLD && tg_q && !running)
    else $error("gate negation did not pause timer");
  AST_IRQ: assert property (IRQ_O == ((tg_q && imask[2])
    || (to_q && imask[1]) || (tc_q && imask[0])))
    else $error("interrupt line disagrees with enabled flags");
  // Pin steady over two samples shows up three edges later
  AST_LEVEL: assert property ($past(RESET_N_I, 4)
    && $past(RESET_N_I, 3) && $past(RESET_N_I, 2) && $past(RESET_N_I)
    && $past(CE_I, 4) && $past(CE_I, 3) && $past(CE_I, 2) && $past(CE_I)
    && $past(GATE_PIN_N_I, 3) == $past(GATE_PIN_N_I, 4)
    |-> stat[`TCS_S_GLVL] == $past(GATE_PIN_N_I, 3))
    else $error("gate level bit does not follow the pin");
endmodule : tcs_timer
`default_nettype wire

// ---- tb/tcs_host.sv ----
// Avalon-MM master model standing in for the processor
`default_nettype none
module tcs_host (
  input  wire logic        clk_i,   // System clock
  input  wire logic        wait_i,  // Slave stall
  input  wire logic [31:0] rdata_i, // Read data
  output logic      [4:0]  addr_o,  // Byte address
  output logic             rd_o,    // Read request
  output logic             wr_o,    // Write request
  output logic      [31:0] wdata_o  // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus from time zero
  initial begin
    addr_o  = 5'h00;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 32'h0000_0000;
  end
  // One transfer, held until the stall drops, then released
  task automatic xfer(input logic rd, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    addr_o  <= a;
    rd_o    <= rd;
    wr_o    <= !rd;
    wdata_o <= d;
    do begin
      @(posedge clk_i);
    end while (wait_i !== 1'b0);
    q = rdata_i;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
  endtask : xfer
endmodule : tcs_host
`default_nettype wire

// ---- tb/tb_tcs_timer.sv ----
// Self-checking bench for the capture/compare and square-wave timer
`default_nettype none
module tb_tcs_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;         // System clock
  logic        rst_n;       // Reset, low
  logic        gate_n;      // Gate pin, asserted low
  logic        ext_clk;     // External count clock
  logic [4:0]  addr;        // Bus address
  logic        rd_req;      // Bus read
  logic        wr_req;      // Bus write
  logic [31:0] wdata;       // Bus write data
  logic [31:0] rdata;       // Bus read data
  logic        stall;       // Bus waitrequest
  logic        wave;        // Waveform pin
  logic        irq;         // Interrupt line
  logic [31:0] q;           // Read result
  logic [31:0] s1;          // First snapshot read
  logic [31:0] s2;          // Second snapshot read
  logic        w;           // Held pin level
  int          err_count;   // Mismatches
  int          checks_done; // Comparisons
  int          cyc;         // Cycle counter
  int          n;           // Model reload value
  int          t0;          // Pin event times
  int          t1;
  int          t2;
  integer      seed;        // Random seed
  int          gap_q[$];    // Model event gaps, in cycles

  // Device under test
  tcs_timer u_tcs_timer (
    .CLK_I            (clk),
    .RESET_N_I        (rst_n),
    .CE_I             (1'b1),
    .AVS_ADDRESS_I    (addr),
    .AVS_BYTEENABLE_I (4'hF),
    .AVS_READ_I       (rd_req),
    .AVS_WRITE_I      (wr_req),
    .AVS_WRITEDATA_I  (wdata),
    .AVS_READDATA_O   (rdata),
    .AVS_WAITREQUEST_O(stall),
    .GATE_PIN_N_I     (gate_n),
    .EXT_CLOCK_PIN_I  (ext_clk),
    .WAVE_O           (wave),
    .IRQ_O            (irq)
  );

  // Processor model on the register bus
  tcs_host u_tcs_host (
    .clk_i  (clk),
    .wait_i (stall),
    .rdata_i(rdata),
    .addr_o (addr),
    .rd_o   (rd_req),
    .wr_o   (wr_req),
    .wdata_o(wdata)
  );

  // Clock generator, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cycle count, free external clock, hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ext_clk <= cyc[1];
    if (cyc >= 20000) begin
      err_count++;
      final_report();
    end
  end

  // Compare seen against expected
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Register access wrappers
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    u_tcs_host.xfer(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    u_tcs_host.xfer(1'b1, a, 32'h0000_0000, q);
  endtask : rd

  // Square-wave run: queue the model's gaps, then compare two
  task automatic sq_run(input logic [31:0] c, input int rl, input int per);
    wr(5'h00, 32'h0000_0000);
    wr(5'h08, rl);
    wr(5'h00, c);
    gap_q.push_back(per);
    gap_q.push_back(per);
    wait_wave(t0);
    wait_wave(t1);
    wait_wave(t2);
    chk("period_a", t1 - t0, gap_q.pop_front());
    chk("period_b", t2 - t1, gap_q.pop_front());
  endtask : sq_run

  // Wait for the next pin change, return its cycle
  task automatic wait_wave(output int t);
    int k;
    logic v;
    k = 0;
    v = wave;
    while (wave === v && k < 2000) begin
      @(posedge clk);
      k++;
    end
    t = cyc;
  endtask : wait_wave

  // Verdict and end of run
  task automatic final_report();
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    rst_n = 1'b0;
    gate_n = 1'b0;
    ext_clk = 1'b0;
    cyc = 0;
    err_count = 0;
    checks_done = 0;
    seed = 92983;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values, unmapped place, reserved bits
    rd(5'h00); chk("ctrl_rst", q, 32'h0000_0000);
    rd(5'h04); chk("stat_rst", q, 32'h0000_0000);
    rd(5'h14); chk("unmapped", q, 32'h0000_0000);
    wr(5'h0C, 32'hFFFF_FFFF);
    rd(5'h0C); chk("match_rsv", q, 32'h0000_FFFF);
    // Square mode, toggle, random reloads, timeout interrupt
    for (int i = 0; i < 3; i++) begin
      n = 2 + ($random(seed) & 3);
      sq_run(32'h0000_1259, n, 2 * (n + 1));
      chk("irq_tmo", irq, 1'b1);
      rd(5'h04); chk("sq_on", q & 32'h16, 32'h0000_0012);
    end
    // Masked flag leaves the line quiet
    wr(5'h00, 32'h0000_1059);
    @(posedge clk);
    chk("irq_mask", irq, 1'b0);
    // Gate pauses square mode
    wr(5'h00, 32'h0000_0000);
    wr(5'h00, 32'h0000_1079);
    repeat (20) @(posedge clk);
    gate_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(5'h04); chk("gate_stop", q & 32'h34, 32'h0000_0024);
    w = wave;
    repeat (40) @(posedge clk);
    chk("gate_hold", wave, w);
    gate_n <= 1'b0;
    repeat (8) @(posedge clk);
    rd(5'h04); chk("gate_go", q & 32'h30, 32'h0000_0010);
    // External pin clock, then the divide-by-256 prescaler
    sq_run(32'h0000_1859, 2, 4 * (2 + 1));
    sq_run(32'h0000_0059, 1, 2 * 256 * (1 + 1));
    // Capture/compare, drive high on match, low on timeout
    wr(5'h00, 32'h0000_0000);
    wr(5'h08, 32'h0000_0008);
    wr(5'h0C, 32'h0000_0007);
    wr(5'h00, 32'h0000_11F8);
    wait_wave(t0);
    chk("match_pin", wave, 1'b1);
    wait_wave(t1);
    chk("tmo_pin", wave, 1'b0);
    chk("match_gap", t1 - t0, 14);
    chk("irq_match", irq, 1'b1);
    rd(5'h04); chk("cap_flags", q & 32'h03, 32'h0000_0003);
    gate_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(5'h04); chk("cap_flag", q & 32'h04, 32'h0000_0004);
    rd(5'h10); s1 = q;
    repeat (10) @(posedge clk);
    rd(5'h10); chk("frozen", q, s1);
    wr(5'h04, 32'h0000_0004);
    rd(5'h04); chk("w1c", q & 32'h04, 32'h0000_0000);
    rd(5'h10); s1 = q;
    repeat (5) @(posedge clk);
    rd(5'h10); s2 = q;
    chk("shadow", s1 != s2, 1'b1);
    chk("snap_rng", s2 <= 32'h0000_0008, 1'b1);
    // Gate disabled in capture mode
    wr(5'h00, 32'h0000_0000);
    wr(5'h00, 32'h0000_11D8);
    gate_n <= 1'b0;
    repeat (8) @(posedge clk);
    gate_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(5'h04); chk("no_cap", q & 32'h24, 32'h0000_0020);
    // Capture square wave: toggle, match at half the reload of 8
    wr(5'h00, 32'h0000_0000);
    wr(5'h0C, 32'h0000_0004);
    gap_q.push_back(2 * 4);
    gap_q.push_back(2 * (8 + 1 - 4));
    wr(5'h00, 32'h0000_1058);
    wait_wave(t0);
    wait_wave(t1);
    wait_wave(t2);
    chk("cap_sq_a", t1 - t0, gap_q.pop_front());
    chk("cap_sq_b", t2 - t1, gap_q.pop_front());
    final_report();
  end
endmodule : tb_tcs_timer
`default_nettype wire
